// *** verilog/tsc_pkg.sv ***
// Shared constants and types of the touch sampling controller
package tsc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 5000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int TICK_US = TICK_NS / 1000;
  localparam int SAMPLE_BASE_US = 320;
  localparam int SAMPLE_BASE_TICKS = SAMPLE_BASE_US / TICK_US;
  localparam int CYCLE_STEP_MS = 35;
  localparam int CYCLE_STEP_TICKS = CYCLE_STEP_MS * 1000 / TICK_US;
  localparam int CAL_TIMEOUT_MS = 600;
  localparam int CAL_TIMEOUT_TICKS = CAL_TIMEOUT_MS * 1000 / TICK_US;
  localparam int NUM_INPUTS = 6;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_STATUS = 6'h03;
  localparam logic [5:0] IDX_GEN_CFG = 6'h20;
  localparam logic [5:0] IDX_SENSE_CFG = 6'h22;
  localparam logic [5:0] IDX_SENSE_CFG2 = 6'h23;
  localparam logic [5:0] IDX_SAMPLING = 6'h24;
  localparam logic [5:0] IDX_CAL_REQ = 6'h26;
  localparam logic [5:0] IDX_IRQ_EN = 6'h27;
  localparam logic [5:0] IDX_REPEAT_EN = 6'h28;

  localparam logic [6:0] RST_SAMPLING = 7'h39;
  localparam logic [5:0] RST_CAL_REQ = 6'h00;
  localparam logic [5:0] RST_IRQ_EN = 6'h3f;
  localparam logic [5:0] RST_REPEAT_EN = 6'h3f;
  localparam logic [7:0] RST_SENSE_CFG = 8'ha4;
  localparam logic [3:0] RST_SENSE_CFG2 = 4'h7;
  localparam logic RST_GEN_CFG = 1'b0;
  localparam logic [5:0] RST_STATUS = 6'h00;

  localparam int SMP_N_LSB = 4;
  localparam int DUR_LSB = 2;
  localparam int CYC_LSB = 0;
  localparam int RATE_LSB = 0;

  typedef enum logic {SQ_SLEEP, SQ_SAMPLE} tsc_seq_t;
  typedef enum logic {CL_IDLE, CL_RUN} tsc_cal_t;
endpackage

// *** verilog/tsc_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module tsc_sync #(
  parameter int W = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Change only once stages two and three agree
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end
  assign dout = out_q;
endmodule // tsc_sync
`default_nettype wire

// *** verilog/tsc_tick.sv ***
// Time base: 5 us tick and 35 ms step pulses
`timescale 1ns/100ps
`default_nettype none
module tsc_tick #(
  parameter int TICK_CYC = tsc_pkg::TICK_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  output logic tick,
  output logic step
);
  logic [11:0] div_q;
  logic [12:0] stp_q;
  wire logic div_end = (div_q == 12'(TICK_CYC - 1));
  wire logic stp_end = (stp_q == 13'(tsc_pkg::CYCLE_STEP_TICKS - 1));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_q <= '0;
      stp_q <= '0;
    end else begin
      div_q <= div_end ? 12'd0 : div_q + 12'd1;
      if (div_end) begin
        stp_q <= stp_end ? 13'd0 : stp_q + 13'd1;
      end
    end
  end
  assign tick = div_end;
  assign step = div_end & stp_end;
endmodule // tsc_tick
`default_nettype wire

// *** verilog/tsc_core.sv ***
// Touch sampling sequencer, recalibration and interrupt control
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tsc_core #(
  parameter int TICK_CYC = tsc_pkg::TICK_CYC,
  parameter int SMP_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [5:0] sense_touch,
  input wire logic [5:0] input_enable,
  input wire logic fully_active,
  input wire logic [SMP_W-1:0] sample_value,
  output logic sample_take,
  output logic [2:0] sample_chan,
  output logic meas_valid,
  output logic [SMP_W-1:0] meas_result,
  output logic low_power,
  output logic cal_start,
  output logic [2:0] cal_chan,
  output logic [5:0] base_invalid,
  input wire logic cal_done,
  input wire logic [9:0] cal_value_in,
  output logic [9:0] calibration_value,
  output logic cal_update,
  output logic irq
);
  localparam int ACC_W = SMP_W + 7;
  localparam int CAL_W = 17;
  function automatic logic addr_is(input logic [7:0] a, input logic [5:0] idx);
    addr_is = (a == {idx, 2'b00});
  endfunction
  // Lowest set bit at or above a start position; 6 means none
  function automatic logic [2:0] next_chan(input logic [5:0] mask, input logic [2:0] from);
    logic [2:0] r;
    r = 3'd6;
    for (int i = 5; i >= 0; i--) begin
      if (mask[i] && (i >= int'(from))) begin
        r = 3'(i);
      end
    end
    next_chan = r;
  endfunction
  logic tick, step;
  logic [5:0] touch_s;
  tsc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick),
    .step(step)
  );
  tsc_sync #(.W(6)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .din(sense_touch),
    .dout(touch_s)
  );
  // Register file
  logic [6:0] sampling_q;
  logic [5:0] cal_req_q, cal_req_d, irq_en_q, repeat_en_q, status_q, status_d;
  logic [7:0] sense_cfg_q;
  logic [3:0] sense_cfg2_q;
  logic supp_q;
  logic [31:0] prdata_q;
  logic [5:0] ev, press_ev, rel_ev, rep_ev, cal_clr, cal_mask;
  wire logic wr_en = psel & penable & pwrite;
  wire logic w_smp = wr_en & addr_is(paddr, tsc_pkg::IDX_SAMPLING);
  wire logic w_cal = wr_en & addr_is(paddr, tsc_pkg::IDX_CAL_REQ);
  wire logic w_ien = wr_en & addr_is(paddr, tsc_pkg::IDX_IRQ_EN);
  wire logic w_rep = wr_en & addr_is(paddr, tsc_pkg::IDX_REPEAT_EN);
  wire logic w_sc1 = wr_en & addr_is(paddr, tsc_pkg::IDX_SENSE_CFG);
  wire logic w_sc2 = wr_en & addr_is(paddr, tsc_pkg::IDX_SENSE_CFG2);
  wire logic w_gen = wr_en & addr_is(paddr, tsc_pkg::IDX_GEN_CFG);
  wire logic w_sts = wr_en & addr_is(paddr, tsc_pkg::IDX_STATUS);
  wire logic mapped = addr_is(paddr, tsc_pkg::IDX_SAMPLING) | addr_is(paddr, tsc_pkg::IDX_CAL_REQ)
    | addr_is(paddr, tsc_pkg::IDX_IRQ_EN) | addr_is(paddr, tsc_pkg::IDX_REPEAT_EN)
    | addr_is(paddr, tsc_pkg::IDX_SENSE_CFG) | addr_is(paddr, tsc_pkg::IDX_SENSE_CFG2)
    | addr_is(paddr, tsc_pkg::IDX_GEN_CFG) | addr_is(paddr, tsc_pkg::IDX_STATUS);
  wire logic [7:0] rd_mux =
    addr_is(paddr, tsc_pkg::IDX_SAMPLING) ? {1'b0, sampling_q} :
    addr_is(paddr, tsc_pkg::IDX_CAL_REQ) ? {2'b00, cal_req_q} :
    addr_is(paddr, tsc_pkg::IDX_IRQ_EN) ? {2'b00, irq_en_q} :
    addr_is(paddr, tsc_pkg::IDX_REPEAT_EN) ? {2'b00, repeat_en_q} :
    addr_is(paddr, tsc_pkg::IDX_SENSE_CFG) ? sense_cfg_q :
    addr_is(paddr, tsc_pkg::IDX_SENSE_CFG2) ? {4'h0, sense_cfg2_q} :
    addr_is(paddr, tsc_pkg::IDX_GEN_CFG) ? {7'h00, supp_q} :
    addr_is(paddr, tsc_pkg::IDX_STATUS) ? {2'b00, status_q} : 8'h00;
  // Hardware set wins over software clear
  assign status_d = (status_q & ~(w_sts ? pwdata[5:0] : 6'h00)) | ev;
  // Write of zero leaves pending requests alone
  assign cal_req_d = (cal_req_q & ~cal_clr) | (w_cal ? pwdata[5:0] : 6'h00);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sampling_q <= tsc_pkg::RST_SAMPLING;
      cal_req_q <= tsc_pkg::RST_CAL_REQ;
      irq_en_q <= tsc_pkg::RST_IRQ_EN;
      repeat_en_q <= tsc_pkg::RST_REPEAT_EN;
      sense_cfg_q <= tsc_pkg::RST_SENSE_CFG;
      sense_cfg2_q <= tsc_pkg::RST_SENSE_CFG2;
      supp_q <= tsc_pkg::RST_GEN_CFG;
      status_q <= tsc_pkg::RST_STATUS;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (w_smp) sampling_q <= pwdata[6:0];
      if (w_ien) irq_en_q <= pwdata[5:0];
      if (w_rep) repeat_en_q <= pwdata[5:0];
      if (w_sc1) sense_cfg_q <= pwdata[7:0];
      if (w_sc2) sense_cfg2_q <= pwdata[3:0];
      if (w_gen) supp_q <= pwdata[0];
      cal_req_q <= cal_req_d;
      status_q <= status_d;
      // Read data captured in setup so the access phase needs no wait
      if (psel && !penable) prdata_q <= {24'h000000, rd_mux};
    end
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign irq = |(status_q & irq_en_q);
  // Sampling sequencer
  tsc_pkg::tsc_seq_t seq_q, seq_d;
  logic [2:0] chan_q, chan_d;
  logic [7:0] cnt_q, cnt_d;
  logic [9:0] dur_q, dur_d;
  logic [ACC_W-1:0] acc_q, acc_d;
  logic [14:0] elapsed_q, elapsed_d;
  logic take_q, take_d, valid_q, valid_d;
  logic [SMP_W-1:0] result_q, result_d;
  wire logic [2:0] code_n = sampling_q[tsc_pkg::SMP_N_LSB +: 3];
  wire logic [1:0] dur_sel = sampling_q[tsc_pkg::DUR_LSB +: 2];
  wire logic [1:0] cyc_sel = sampling_q[tsc_pkg::CYC_LSB +: 2];
  wire logic [7:0] n_last = 8'((9'd1 << code_n) - 9'd1);
  wire logic [9:0] dur_last = 10'((10'(tsc_pkg::SAMPLE_BASE_TICKS) << dur_sel) - 10'd1);
  wire logic [14:0] cycle_ticks = 15'(tsc_pkg::CYCLE_STEP_TICKS * (int'(cyc_sel) + 1));
  // Elapsed keeps running while sampling, so after an overrun the next cycle starts at once
  wire logic cycle_due = fully_active && (elapsed_q >= cycle_ticks);
  wire logic [2:0] first_ch = next_chan(input_enable, 3'd0);
  wire logic [2:0] next_ch = next_chan(input_enable, chan_q + 3'd1);
  wire logic [ACC_W-1:0] acc_sum = acc_q + ACC_W'(sample_value);
  always_comb begin
    seq_d = seq_q;
    chan_d = chan_q;
    cnt_d = cnt_q;
    dur_d = dur_q;
    acc_d = acc_q;
    take_d = 1'b0;
    valid_d = 1'b0;
    result_d = result_q;
    elapsed_d = (tick && elapsed_q != 15'h7fff) ? elapsed_q + 15'd1 : elapsed_q;
    case (seq_q)
      tsc_pkg::SQ_SLEEP: begin
        if (cycle_due) begin
          elapsed_d = 15'd0;
          chan_d = first_ch;
          cnt_d = 8'd0;
          dur_d = 10'd0;
          acc_d = '0;
          if (first_ch != 3'd6) seq_d = tsc_pkg::SQ_SAMPLE;
        end
      end
      tsc_pkg::SQ_SAMPLE: begin
        if (tick) begin
          if (dur_q == dur_last) begin
            dur_d = 10'd0;
            take_d = 1'b1;
            acc_d = acc_sum;
            if (cnt_q == n_last) begin
              valid_d = 1'b1;
              result_d = SMP_W'(acc_sum >> code_n);
              acc_d = '0;
              cnt_d = 8'd0;
              chan_d = next_ch;
              if (next_ch == 3'd6) seq_d = tsc_pkg::SQ_SLEEP;
            end else begin
              cnt_d = cnt_q + 8'd1;
            end
          end else begin
            dur_d = dur_q + 10'd1;
          end
        end
      end
      default: seq_d = tsc_pkg::SQ_SLEEP;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq_q <= tsc_pkg::SQ_SLEEP;
      chan_q <= 3'd0;
      cnt_q <= 8'd0;
      dur_q <= 10'd0;
      acc_q <= '0;
      elapsed_q <= 15'd0;
      take_q <= 1'b0;
      valid_q <= 1'b0;
      result_q <= '0;
    end else begin
      seq_q <= seq_d;
      chan_q <= chan_d;
      cnt_q <= cnt_d;
      dur_q <= dur_d;
      acc_q <= acc_d;
      elapsed_q <= elapsed_d;
      take_q <= take_d;
      valid_q <= valid_d;
      result_q <= result_d;
    end
  end
  assign sample_take = take_q;
  assign sample_chan = chan_q;
  assign meas_valid = valid_q;
  assign meas_result = result_q;
  assign low_power = (seq_q == tsc_pkg::SQ_SLEEP);
  // Recalibration engine, one input at a time
  tsc_pkg::tsc_cal_t cal_q, cal_d;
  logic [2:0] cch_q, cch_d;
  logic [CAL_W-1:0] ctmr_q, ctmr_d;
  logic cstart_q, cstart_d, upd_q, upd_d;
  logic [9:0] cval_q, cval_d;
  wire logic [2:0] cal_pick = next_chan(cal_req_q, 3'd0);
  wire logic cal_run = (cal_q == tsc_pkg::CL_RUN);
  always_comb begin
    cal_d = cal_q;
    cch_d = cch_q;
    ctmr_d = ctmr_q;
    cstart_d = 1'b0;
    upd_d = 1'b0;
    cval_d = cval_q;
    cal_clr = 6'h00;
    case (cal_q)
      tsc_pkg::CL_IDLE: begin
        if (cal_pick != 3'd6) begin
          cal_d = tsc_pkg::CL_RUN;
          cch_d = cal_pick;
          ctmr_d = '0;
          cstart_d = 1'b1;
        end
      end
      tsc_pkg::CL_RUN: begin
        // Retry on a touch or a timeout; the request bit stays set
        if (touch_s[cch_q]) begin
          cal_d = tsc_pkg::CL_IDLE;
        end else if (cal_done) begin
          cal_d = tsc_pkg::CL_IDLE;
          cal_clr[cch_q] = 1'b1;
          upd_d = 1'b1;
          cval_d = cal_value_in;
        end else if (ctmr_q == CAL_W'(tsc_pkg::CAL_TIMEOUT_TICKS - 1)) begin
          cal_d = tsc_pkg::CL_IDLE;
        end else if (tick) begin
          ctmr_d = ctmr_q + CAL_W'(1);
        end
      end
      default: cal_d = tsc_pkg::CL_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cal_q <= tsc_pkg::CL_IDLE;
      cch_q <= 3'd0;
      ctmr_q <= '0;
      cstart_q <= 1'b0;
      upd_q <= 1'b0;
      cval_q <= 10'd0;
    end else begin
      cal_q <= cal_d;
      cch_q <= cch_d;
      ctmr_q <= ctmr_d;
      cstart_q <= cstart_d;
      upd_q <= upd_d;
      cval_q <= cval_d;
    end
  end
  assign cal_mask = cal_run ? 6'(6'd1 << cch_q) : 6'h00;
  assign base_invalid = cal_mask;
  assign cal_start = cstart_q;
  assign cal_chan = cch_q;
  assign cal_update = upd_q;
  assign calibration_value = cval_q;
  // Per-input touch, release and repeat events
  wire logic [3:0] rate = sense_cfg_q[tsc_pkg::RATE_LSB +: 4];
  for (genvar i = 0; i < tsc_pkg::NUM_INPUTS; i++) begin : g_in
    logic prev_q, held_q;
    logic [4:0] steps_q;
    wire logic now_t = touch_s[i] & ~cal_mask[i];
    // Granularity is one 35 ms step; the first interval may run short
    wire logic [4:0] goal = held_q ? 5'({1'b0, rate}) + 5'd1
                                   : 5'({1'b0, sense_cfg2_q}) + 5'd1;
    wire logic hit = now_t & step & (steps_q + 5'd1 == goal);
    assign press_ev[i] = now_t & ~prev_q;
    assign rel_ev[i] = ~now_t & prev_q;
    assign rep_ev[i] = hit & held_q & repeat_en_q[i];
    assign ev[i] = press_ev[i] | (rel_ev[i] & ~supp_q) | rep_ev[i];
    always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
        prev_q <= 1'b0;
        held_q <= 1'b0;
        steps_q <= 5'd0;
      end else begin
        prev_q <= now_t;
        if (press_ev[i] || !now_t) begin
          held_q <= 1'b0;
          steps_q <= 5'd0;
        end else if (hit) begin
          held_q <= 1'b1;
          steps_q <= 5'd0;
        end else if (step) begin
          steps_q <= steps_q + 5'd1;
        end
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_avg_count: assert property (valid_q |-> $past(cnt_q) == $past(n_last))
    else $error("measurement ended after wrong sample count");
  a_chan_hold: assert property (take_q && !valid_q |-> chan_q == $past(chan_q))
    else $error("channel changed before its samples were done");
  a_sample_len: assert property (take_q |-> $past(tick) && $past(dur_q) == $past(dur_last))
    else $error("sample ended at wrong time");
  a_cycle_start: assert property ($rose(seq_q == tsc_pkg::SQ_SAMPLE)
    |-> $past(elapsed_q) >= $past(cycle_ticks) && $past(fully_active))
    else $error("cycle started early");
  a_sleep_idle: assert property (low_power && !fully_active |=> low_power)
    else $error("sampling started while not fully active");
  a_cal_clear: assert property (upd_q && !$past(w_cal) |-> !cal_req_q[$past(cch_q)])
    else $error("request bit kept after recalibration");
  a_cal_keep: assert property (cal_run && !cal_done && w_cal && pwdata[5:0] == 6'h00
    |=> cal_req_q[$past(cch_q)])
    else $error("zero write cancelled recalibration");
  a_touch_abort: assert property (cal_run && touch_s[cch_q] |=> !cal_run && !upd_q)
    else $error("touched recalibration not voided");
  a_no_press: assert property ((press_ev & cal_mask) == 6'h00)
    else $error("press reported during recalibration");
  a_rep_off: assert property (!repeat_en_q[0] |-> !rep_ev[0])
    else $error("repeat event while repeat disabled");
  a_rel_irq: assert property (rel_ev[0] && !supp_q && irq_en_q[0] |=> status_q[0] && irq)
    else $error("release did not interrupt");
  c_meas: cover property (valid_q && n_last == 8'd7);
  c_overrun: cover property (low_power && cycle_due && elapsed_q > cycle_ticks);
  c_repeat: cover property (rep_ev[0]);
endmodule // tsc_core
`default_nettype wire

// *** sim/tsc_fe_model.sv ***
// Front-end model: answers recalibration and supplies sample values
`timescale 1ns/100ps
`default_nettype none
module tsc_fe_model #(
  parameter int CAL_LAT = 200,
  parameter logic [9:0] CAL_VAL = 10'h2a5,
  parameter logic [15:0] SMP_VAL = 16'h0123
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cal_start,
  output logic cal_done,
  output logic [9:0] cal_value_in,
  output logic [15:0] sample_value
);
  int cnt_q;
  // Every start restarts the wait, so an aborted attempt never completes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
      cal_done <= 1'b0;
    end else begin
      cal_done <= (cnt_q == 1);
      if (cal_start === 1'b1) begin
        cnt_q <= CAL_LAT;
      end else if (cnt_q != 0) begin
        cnt_q <= cnt_q - 1;
      end
    end
  end
  // Value only meaningful with the done pulse, inverted otherwise
  assign cal_value_in = cal_done ? CAL_VAL : ~CAL_VAL;
  assign sample_value = SMP_VAL;
endmodule // tsc_fe_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench of the touch sampling controller
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] sense_touch = 6'h00;
  logic [5:0] input_enable = 6'h21;
  logic fully_active = 1'b1;
  logic [31:0] prdata, rd;
  logic pready, pslverr, sample_take, meas_valid, low_power, cal_start, cal_done, cal_update;
  logic irq, err;
  logic [2:0] sample_chan, cal_chan;
  logic [15:0] sample_value, meas_result;
  logic [5:0] base_invalid;
  logic [9:0] cal_value_in, calibration_value;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int rel = 0;
  int ncal = 0;
  int nfall = 0;

  tsc_core #(.TICK_CYC(1), .SMP_W(16)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sense_touch(sense_touch), .input_enable(input_enable),
    .fully_active(fully_active), .sample_value(sample_value), .sample_take(sample_take),
    .sample_chan(sample_chan), .meas_valid(meas_valid), .meas_result(meas_result),
    .low_power(low_power), .cal_start(cal_start), .cal_chan(cal_chan),
    .base_invalid(base_invalid), .cal_done(cal_done), .cal_value_in(cal_value_in),
    .calibration_value(calibration_value), .cal_update(cal_update), .irq(irq));
  tsc_fe_model u_fe (.sys_clk(sys_clk), .rst(rst), .cal_start(cal_start),
    .cal_done(cal_done), .cal_value_in(cal_value_in), .sample_value(sample_value));

  always #5 sys_clk = ~sys_clk;

  // Counters use non-blocking updates so tasks see stable values
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cal_start === 1'b1) ncal <= ncal + 1;
    if ($fell(low_power)) nfall <= nfall + 1;
    if (cyc == 105000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Entered just after an edge; holds the request until pready is sampled
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wait_fall;
    logic p;
    int n;
    p = 1'b0;
    n = 0;
    while (!(p === 1'b1 && low_power === 1'b0) && n < 20000) begin
      p = low_power;
      @(posedge sys_clk);
      n++;
    end
  endtask

  task automatic t_regs;
    rchk("sampling_config", 8'h90, 32'h39);
    rchk("calibration_request", 8'h98, 32'h0);
    rchk("touch_interrupt_enable", 8'h9c, 32'h3f);
    rchk("auto_repeat_enable", 8'ha0, 32'h3f);
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped error", 32'h1, {31'h0, err});
  endtask

  task automatic t_cal;
    int n;
    apb(1'b1, 8'h98, 32'h4);
    n = 0;
    while (cal_start !== 1'b1 && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    chk("cal channel", 32'h2, {29'h0, cal_chan});
    chk("base invalid", 32'h4, {26'h0, base_invalid});
    apb(1'b1, 8'h98, 32'h0);
    rchk("request kept", 8'h98, 32'h4);
    sense_touch <= 6'h04;
    idle(20);
    sense_touch <= 6'h00;
    n = 0;
    while (cal_update !== 1'b1 && n < 600) begin
      @(posedge sys_clk);
      n++;
    end
    chk("retried after touch", 32'h1, {31'h0, (ncal > 1)});
    chk("calibration value", 32'h2a5, {22'h0, calibration_value});
    chk("base valid", 32'h0, {26'h0, base_invalid});
    rchk("request cleared", 8'h98, 32'h0);
  endtask

  task automatic t_first;
    wait_fall();
    chk("first cycle", 32'h1, {31'h0, (cyc - rel >= 14000 && cyc - rel <= 14006)});
  endtask

  task automatic t_irq;
    int nf;
    apb(1'b1, 8'h0c, 32'h3f);
    apb(1'b1, 8'h9c, 32'h3e);
    apb(1'b1, 8'ha0, 32'h0);
    sense_touch <= 6'h01;
    idle(10);
    rchk("press status", 8'h0c, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h9c, 32'h3f);
    chk("irq enabled", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h0c, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq});
    sense_touch <= 6'h00;
    idle(10);
    rchk("release status", 8'h0c, 32'h1);
    apb(1'b1, 8'h0c, 32'h3f);
    apb(1'b1, 8'h80, 32'h1);
    sense_touch <= 6'h01;
    idle(10);
    apb(1'b1, 8'h0c, 32'h3f);
    sense_touch <= 6'h00;
    idle(10);
    rchk("release suppressed", 8'h0c, 32'h0);
    // Short touch with repeat on: release still reported
    apb(1'b1, 8'h80, 32'h0);
    apb(1'b1, 8'ha0, 32'h1);
    sense_touch <= 6'h01;
    idle(10);
    apb(1'b1, 8'h0c, 32'h3f);
    sense_touch <= 6'h00;
    idle(10);
    rchk("short touch release", 8'h0c, 32'h1);
    apb(1'b1, 8'h8c, 32'h0);
    apb(1'b1, 8'h88, 32'h0);
    apb(1'b1, 8'ha0, 32'h1);
    fully_active <= 1'b0;
    sense_touch <= 6'h03;
    idle(10);
    apb(1'b1, 8'h0c, 32'h3f);
    nf = nfall;
    idle(14100);
    rchk("repeat status", 8'h0c, 32'h1);
    chk("no cycle while idle", 32'(nf), 32'(nfall));
    sense_touch <= 6'h00;
    fully_active <= 1'b1;
    idle(10);
    apb(1'b1, 8'h0c, 32'h3f);
  endtask

  // Last setting overruns the cycle, so its config is written last
  task automatic t_avg;
    int c, d, nch, act, takes, meas, gap, last, t0, tp, ep;
    logic [5:0] ch;
    logic [2:0] pc;
    tp = 0;
    ep = 0;
    for (c = 0; c < 8; c++) begin
      d = (c < 4) ? c : 0;
      nch = (c < 3) ? 2 : 1;
      input_enable <= (nch == 2) ? 6'h21 : 6'h01;
      apb(1'b1, 8'h90, {25'h0, c[2:0], d[1:0], 2'b00});
      wait_fall();
      t0 = cyc;
      if (c > 0) chk("period", 32'h1, {31'h0, (t0 - tp >= ep && t0 - tp <= ep + 16)});
      act = 0;
      takes = 0;
      meas = 0;
      gap = 0;
      last = 0;
      ch = 6'h00;
      // Channel moves on with the valid pulse, so keep last cycle's value
      pc = sample_chan;
      while (low_power !== 1'b1 && act < 20000) begin
        @(posedge sys_clk);
        act++;
        if (sample_take === 1'b1) begin
          if (takes == 1) gap = act - last;
          last = act;
          takes++;
        end
        if (meas_valid === 1'b1) begin
          meas++;
          ch = {ch[2:0], pc};
          chk("average", 32'h123, {16'h0, meas_result});
        end
        pc = sample_chan;
      end
      ep = (nch * (64 << d)) << c;
      chk("samples", 32'(nch << c), 32'(takes));
      chk("active time", 32'h1, {31'h0, (act >= ep && act <= ep + 16)});
      if (c > 0) chk("sample time", 32'h1, {31'h0, (gap >= (64 << d) && gap <= (64 << d) + 2)});
      chk("channel order", (nch == 2) ? 32'o05 : 32'o00, {26'h0, ch});
      chk("results", 32'(nch), 32'(meas));
      if (ep < 7000) ep = 7000;
      tp = t0;
    end
    wait_fall();
    chk("stretched period", 32'h1, {31'h0, (cyc - tp >= ep && cyc - tp <= ep + 16)});
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rel = cyc;
    t_regs();
    t_cal();
    t_first();
    t_irq();
    t_avg();
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
